// [logic/ssp_defs.svh]
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// Register offsets on the 8-bit register port
`define SSP_OFS_CTRL 8'h28
`define SSP_OFS_STAT 8'h29
`define SSP_OFS_DATA 8'h2A
`define SSP_OFS_MASK 8'h2B
`define SSP_OFS_OPTIONS_SECOND_REG 8'h38

// Status bit positions
`define SSP_ST_DONE 7
`define SSP_ST_WRITE_COLLISION_FLAG 6
`define SSP_ST_FAULT 4

// Options register bit positions
`define SSP_OPT_LOW_BIT_FIRST 3
`define SSP_OPT_PRE 2

// Reset values
`define SSP_CTRL_RST 8'h04
`define SSP_OPTIONS_SECOND_REG_RST 8'h00
`define SSP_MASK_RST 8'hD0
`define SSP_DATA_RST 8'h00

// Half periods of the serial clock in bus clocks, per rate select
`define SSP_HALF_0 9'h001
`define SSP_HALF_1 9'h002
`define SSP_HALF_2 9'h008
`define SSP_HALF_3 9'h010
`define SSP_HALF_4 9'h004
`define SSP_HALF_5 9'h008
`define SSP_HALF_6 9'h020
`define SSP_HALF_7 9'h040

// Bits per transfer and edges per master byte
`define SSP_BITS 4'h8
`define SSP_EDGES 5'h10
// Synchroniser depth plus the pin register, as seen by the master sampler
`define SSP_SYNC_LAG 3

`endif

// [logic/ssp_pkg.sv]
package ssp_pkg;

  // Control register fields
  typedef struct packed {
    logic irq_enable_bit;
    logic port_on_bit;
    logic open_drain_select;
    logic controller_role_bit;
    logic clock_idle_level;
    logic clock_sample_phase;
    logic [1:0] rate_lo;
  } ssp_ctrl_t;

  // Driven pin levels before the output stage
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } ssp_pins_t;

  // Master clock generator state
  typedef enum logic {
    SSP_IDLE = 1'b0,
    SSP_RUN = 1'b1
  } ssp_state_t;

endpackage : ssp_pkg

// [logic/ssp_port.sv]
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_port #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt
  output logic irq_o,
  // Serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  // Controller-out data pin
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  // Controller-in data pin
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  // Slave select pin, input only
  input wire logic ss_n_i
);

  // Offsets need eight address bits
  if (ADDR_W < 8) begin : g_chk
    $error("ssp_port: ADDR_W must be at least 8");
  end

  ssp_pkg::ssp_ctrl_t ctrl_q;
  ssp_pkg::ssp_state_t state_q;
  ssp_pkg::ssp_pins_t pins_q;
  logic [7:0] options_second_reg_q, mask_q, rxbuf_q, txsr_q, rxsr_q, rdata_q;
  logic done_q, write_collision_flag_q, fault_q;
  logic arm_done_q, arm_write_collision_flag_q, arm_fault_q;
  logic [3:0] sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
  logic [8:0] div_q;
  logic [4:0] edge_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [`SSP_SYNC_LAG-1:0] samp_pipe_q;
  logic sck_q, busy_q, skip_q;
  logic sel_ctrl, sel_stat, sel_data, sel_mask, sel_options_second_reg;
  logic wr_data, acc_data, wr_ctrl, rd_stat;
  logic is_master, slave_sel, fault_ev;
  logic s_lead, s_trail, m_tog, m_lead, m_trail;
  logic lead, trail, launch, sample_ev, sample_bit, start, done_ev;
  logic [8:0] half;
  logic [7:0] stat_v;

  // Rate table, optionally stretched by four
  function automatic logic [8:0] half_period(input logic [2:0] sel);
    logic [8:0] h;
    h = `SSP_HALF_0;
    unique case (sel[1:0])
      2'h0: h = sel[2] ? `SSP_HALF_4 : `SSP_HALF_0;
      2'h1: h = sel[2] ? `SSP_HALF_5 : `SSP_HALF_1;
      2'h2: h = sel[2] ? `SSP_HALF_6 : `SSP_HALF_2;
      2'h3: h = sel[2] ? `SSP_HALF_7 : `SSP_HALF_3;
    endcase
    return h;
  endfunction : half_period

  // Address decode
  always_comb begin
    sel_ctrl = (reg_addr_i == ADDR_W'(`SSP_OFS_CTRL));
    sel_stat = (reg_addr_i == ADDR_W'(`SSP_OFS_STAT));
    sel_data = (reg_addr_i == ADDR_W'(`SSP_OFS_DATA));
    sel_mask = (reg_addr_i == ADDR_W'(`SSP_OFS_MASK));
    sel_options_second_reg = (reg_addr_i == ADDR_W'(`SSP_OFS_OPTIONS_SECOND_REG));
    wr_data = reg_wr_i && sel_data;
    acc_data = (reg_wr_i || reg_rd_i) && sel_data;
    wr_ctrl = reg_wr_i && sel_ctrl;
    rd_stat = reg_rd_i && sel_stat;
  end

  // Pin synchronisers; bit 0 feeds only bit 1
  // Upper stages only serve edge detection; spare bits cost little
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sck_s_q <= 4'h0;
      mosi_s_q <= 4'h0;
      miso_s_q <= 4'h0;
      ss_s_q <= 4'hF;
    end else begin
      sck_s_q <= {sck_s_q[2:0], sck_i};
      mosi_s_q <= {mosi_s_q[2:0], mosi_i};
      miso_s_q <= {miso_s_q[2:0], miso_i};
      ss_s_q <= {ss_s_q[2:0], ss_n_i};
    end
  end

  // Role and edge decode
  always_comb begin
    is_master = ctrl_q.port_on_bit && ctrl_q.controller_role_bit;
    slave_sel = ctrl_q.port_on_bit && !ctrl_q.controller_role_bit
                && !ss_s_q[1];
    fault_ev = is_master && !ss_s_q[1];
    s_lead = slave_sel && (sck_s_q[1] != sck_s_q[2])
             && (sck_s_q[2] == ctrl_q.clock_idle_level);
    s_trail = slave_sel && (sck_s_q[1] != sck_s_q[2])
              && (sck_s_q[1] == ctrl_q.clock_idle_level);
    half = half_period({options_second_reg_q[`SSP_OPT_PRE], ctrl_q.rate_lo});
    m_tog = (state_q == ssp_pkg::SSP_RUN) && (div_q == 9'h001);
    m_lead = m_tog && !edge_cnt_q[0];
    m_trail = m_tog && edge_cnt_q[0];
    lead = is_master ? m_lead : s_lead;
    trail = is_master ? m_trail : s_trail;
    launch = ctrl_q.clock_sample_phase ? lead : trail;
    // Master samples late to match the synchroniser lag
    sample_ev = is_master ? samp_pipe_q[`SSP_SYNC_LAG-1]
                          : (ctrl_q.clock_sample_phase ? trail : lead);
    sample_bit = is_master ? miso_s_q[1] : mosi_s_q[1];
    start = wr_data && !busy_q && is_master;
    done_ev = sample_ev && (bit_cnt_q == (`SSP_BITS - 4'h1));
  end

  // Control register; a fault drops port and role bits
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_q <= `SSP_CTRL_RST;
    end else if (fault_ev) begin
      ctrl_q.port_on_bit <= 1'b0;
      ctrl_q.controller_role_bit <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i;
    end
  end

  // Options and mask registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      options_second_reg_q <= `SSP_OPTIONS_SECOND_REG_RST;
      mask_q <= `SSP_MASK_RST;
    end else begin
      if (reg_wr_i && sel_options_second_reg) begin
        options_second_reg_q <= reg_wdata_i;
      end
      if (reg_wr_i && sel_mask) begin
        mask_q <= reg_wdata_i;
      end
    end
  end

  // Master clock generator
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= ssp_pkg::SSP_IDLE;
      div_q <= 9'h000;
      edge_cnt_q <= 5'h00;
      sck_q <= 1'b0;
    end else begin
      unique case (state_q)
        ssp_pkg::SSP_IDLE: begin
          sck_q <= ctrl_q.clock_idle_level;
          edge_cnt_q <= 5'h00;
          div_q <= half;
          if (start) begin
            state_q <= ssp_pkg::SSP_RUN;
          end
        end
        ssp_pkg::SSP_RUN: begin
          if (!is_master) begin
            state_q <= ssp_pkg::SSP_IDLE; // Fault or port off
          end else if (m_tog) begin
            sck_q <= !sck_q;
            div_q <= half;
            edge_cnt_q <= edge_cnt_q + 5'h01;
            if (edge_cnt_q == (`SSP_EDGES - 5'h01)) begin
              state_q <= ssp_pkg::SSP_IDLE;
            end
          end else begin
            div_q <= div_q - 9'h001;
          end
        end
      endcase
    end
  end

  // Delayed sample strobe for the master
  // Two synchroniser flops plus the pin register: sampling any earlier
  // would catch the previous bit at the fastest rate
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      samp_pipe_q <= '0;
    end else begin
      samp_pipe_q <= {samp_pipe_q[`SSP_SYNC_LAG-2:0],
                      is_master && (ctrl_q.clock_sample_phase ? m_trail : m_lead)};
    end
  end

  // Busy tracking; slave drops the byte when deselected
  // A deselect mid-byte loses the partial byte on purpose
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
    end else if (!is_master && !slave_sel) begin
      busy_q <= 1'b0;
    end else if (done_ev) begin
      busy_q <= 1'b0;
    end else if (start || s_lead) begin
      busy_q <= 1'b1;
    end
  end

  // Transmit shifter, loaded straight from a data write
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      txsr_q <= `SSP_DATA_RST;
      skip_q <= 1'b0;
    end else if (wr_data && !busy_q) begin
      txsr_q <= reg_wdata_i;
      skip_q <= ctrl_q.clock_sample_phase;
    end else if (launch) begin
      if (skip_q) begin
        skip_q <= 1'b0; // First leading edge only presents bit
      end else if (options_second_reg_q[`SSP_OPT_LOW_BIT_FIRST]) begin
        txsr_q <= {1'b0, txsr_q[7:1]};
      end else begin
        txsr_q <= {txsr_q[6:0], 1'b0};
      end
    end
  end

  // Receive shifter and count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rxsr_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if ((!is_master && !slave_sel) || start) begin
      bit_cnt_q <= 4'h0;
    end else if (sample_ev) begin
      bit_cnt_q <= done_ev ? 4'h0 : bit_cnt_q + 4'h1;
      if (options_second_reg_q[`SSP_OPT_LOW_BIT_FIRST]) begin
        rxsr_q <= {sample_bit, rxsr_q[7:1]};
      end else begin
        rxsr_q <= {rxsr_q[6:0], sample_bit};
      end
    end
  end

  // Receive buffer; readable while the next byte shifts
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rxbuf_q <= 8'h00;
    end else if (done_ev) begin
      rxbuf_q <= options_second_reg_q[`SSP_OPT_LOW_BIT_FIRST] ? {sample_bit, rxsr_q[7:1]}
                                       : {rxsr_q[6:0], sample_bit};
    end
  end

  // Arming by status read; cleared by the clearing access
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      arm_done_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
      arm_fault_q <= 1'b0;
    end else if (rd_stat) begin
      arm_done_q <= done_q;
      arm_write_collision_flag_q <= write_collision_flag_q;
      arm_fault_q <= fault_q;
    end else begin
      if (acc_data) begin
        arm_done_q <= 1'b0;
        arm_write_collision_flag_q <= 1'b0;
      end
      if (wr_ctrl) begin
        arm_fault_q <= 1'b0;
      end
    end
  end

  // Status flags; a set in the clearing cycle wins
  // Clearing needs a status read first, so stray accesses are harmless
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (done_ev) begin
        done_q <= 1'b1;
      end else if (acc_data && arm_done_q) begin
        done_q <= 1'b0;
      end
      if (wr_data && busy_q) begin
        write_collision_flag_q <= 1'b1;
      end else if (acc_data && arm_write_collision_flag_q) begin
        write_collision_flag_q <= 1'b0;
      end
      if (fault_ev) begin
        fault_q <= 1'b1;
      end else if (wr_ctrl && arm_fault_q) begin
        fault_q <= 1'b0;
      end
    end
  end

  // Status image; empty positions stay zero
  always_comb begin
    stat_v = 8'h00;
    stat_v[`SSP_ST_DONE] = done_q;
    stat_v[`SSP_ST_WRITE_COLLISION_FLAG] = write_collision_flag_q;
    stat_v[`SSP_ST_FAULT] = fault_q;
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= sel_ctrl ? ctrl_q :
                 sel_stat ? stat_v :
                 sel_data ? rxbuf_q :
                 sel_mask ? mask_q :
                 sel_options_second_reg ? options_second_reg_q : 8'h00;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  // Level interrupt; flags still visible when enable is off
  assign irq_o = ctrl_q.irq_enable_bit && |(stat_v & mask_q);

  // Registered pin levels
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pins_q <= '0;
    end else begin
      pins_q.sck <= sck_q;
      pins_q.mosi <= options_second_reg_q[`SSP_OPT_LOW_BIT_FIRST] ? txsr_q[0] : txsr_q[7];
      pins_q.miso <= options_second_reg_q[`SSP_OPT_LOW_BIT_FIRST] ? txsr_q[0] : txsr_q[7];
    end
  end

  // Output stage; open drain only ever pulls low
  // Released pins rely on board pull-ups in open-drain mode
  always_comb begin
    sck_o = ctrl_q.open_drain_select ? 1'b0 : pins_q.sck;
    mosi_o = ctrl_q.open_drain_select ? 1'b0 : pins_q.mosi;
    miso_o = ctrl_q.open_drain_select ? 1'b0 : pins_q.miso;
    sck_oe_n_o = !(is_master && (!ctrl_q.open_drain_select || !pins_q.sck));
    mosi_oe_n_o = !(is_master && (!ctrl_q.open_drain_select || !pins_q.mosi));
    miso_oe_n_o = !(slave_sel && (!ctrl_q.open_drain_select || !pins_q.miso));
  end

endmodule : ssp_port

// [sim/ssp_slave_model.sv]
`timescale 1ns/1ps
module ssp_slave_model (
  // Link pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  output logic miso_o,
  // Agreed format and data
  input wire logic clock_idle_level_i,
  input wire logic clock_sample_phase_i,
  input wire logic low_bit_first_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sh;
  logic first;
  wire bit_w = low_bit_first_i ? sh[0] : sh[7];
  // Released line shows the inverse, never a stale copy
  assign miso_o = sel_n_i ? !bit_w : bit_w;
  // Load on select
  always @(negedge sel_n_i) begin
    sh = tx_i;
    first = 1'b1;
  end
  // Sample on one edge, launch on the other
  always @(sck_i) begin
    if (!sel_n_i) begin
      if (sck_i ^ clock_idle_level_i ^ clock_sample_phase_i) begin
        rx_o = low_bit_first_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      end else if (clock_sample_phase_i && first) begin
        first = 1'b0;
      end else begin
        sh = low_bit_first_i ? sh >> 1 : sh << 1;
      end
    end
  end
endmodule : ssp_slave_model

// [sim/ssp_port_asserts.sv]
`timescale 1ns/1ps
module ssp_port_asserts #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic irq_o,
  // Pins
  input wire logic sck_o,
  input wire logic sck_oe_n_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_n_o,
  input wire logic ss_n_i
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // Half periods per rate select
  localparam logic [8:0] HALF [8] = '{9'h001, 9'h002, 9'h008, 9'h010,
    9'h004, 9'h008, 9'h020, 9'h040};
  logic [7:0] ctl_q;
  logic pre_q;
  logic sck_q;
  logic oe_q;
  logic [8:0] gap_q;
  wire wctl = reg_wr_i && reg_addr_i == ADDR_W'(8'h28);
  wire tog = !sck_oe_n_o && !oe_q && sck_o != sck_q;
  wire [8:0] half = HALF[{pre_q, ctl_q[1:0]}];
  // Shadow of control writes; fault clearing is not mirrored
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctl_q <= 8'h04;
      pre_q <= 1'b0;
      gap_q <= 9'h1FF;
    end else begin
      if (wctl) begin
        ctl_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == ADDR_W'(8'h38)) begin
        pre_q <= reg_wdata_i[2];
      end
      gap_q <= tog ? 9'h001 : gap_q + {8'h00, gap_q != 9'h1FF};
    end
    sck_q <= sck_o;
    oe_q <= sck_oe_n_o;
  end
  stat_pad_a: assert property (
    reg_rd_i && reg_addr_i == ADDR_W'(8'h29) |=> (reg_rdata_o & 8'h2F) == 8'h00)
    else $error("status pad bits set");
  irq_gate_a: assert property (irq_o |-> ctl_q[7])
    else $error("interrupt while disabled");
  off_quiet_a: assert property (
    wctl && !reg_wdata_i[6] |-> ##2 sck_oe_n_o && mosi_oe_n_o)
    else $error("pins driven while off");
  od_low_a: assert property (
    wctl && reg_wdata_i[5] |-> ##2 !(sck_o || mosi_o))
    else $error("open drain output high");
  ctl_drive_a: assert property (
    wctl && reg_wdata_i[6:4] == 3'h5 |-> ##2 !sck_oe_n_o)
    else $error("master clock not driven");
  sck_role_a: assert property (
    !sck_oe_n_o |-> ctl_q[6] && ctl_q[4] || $past(ctl_q[6] && ctl_q[4], 2))
    else $error("clock driven outside master role");
  fault_stop_a: assert property (
    $fell(ss_n_i) && ctl_q[6] && ctl_q[4] |-> ##4 sck_oe_n_o && mosi_oe_n_o)
    else $error("fault did not stop master");
  sck_rate_a: assert property (
    tog |-> gap_q == half || gap_q > {half[7:0], 1'b0} + 9'h004)
    else $error("serial clock half period wrong");
  cover property (tog);
  cover property (irq_o);
  cover property ($fell(ss_n_i) && ctl_q[4]);
endmodule : ssp_port_asserts

bind ssp_port ssp_port_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .sck_o(sck_o),
  .sck_oe_n_o(sck_oe_n_o), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
  .ss_n_i(ss_n_i));

// [sim/ssp_port_tb_top.sv]
`timescale 1ns/1ps
module ssp_port_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ss_n_i = 1'b1;
  logic sel_n = 1'b1;
  logic [7:0] reg_rdata_o, got, ctl, opt, mask, tx, dat, mrx;
  logic irq_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_w;
  logic miso_o, miso_oe_n_o;
  logic sck_m = 1'b1;
  logic mosi_m = 1'b1;
  logic [7:0] srx = 8'h00;
  logic [31:0] seed = 32'h43C4C238;
  logic [31:0] r;
  int num_errors = 0;
  int num_checks = 0;
  int k;
  // Released lines show the bench level, which idles high as a pull-up
  wire sck_w = sck_oe_n_o ? sck_m : sck_o;
  wire mosi_w = mosi_oe_n_o ? mosi_m : mosi_o;
  wire miso_d = miso_oe_n_o | miso_o;

  ssp_port u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o),
    .ss_n_i(ss_n_i));
  ssp_slave_model u_slave (
    .sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(sel_n), .miso_o(miso_w),
    .clock_idle_level_i(ctl[3]), .clock_sample_phase_i(ctl[2]), .low_bit_first_i(opt[3]), .tx_i(tx), .rx_o(mrx));

  // Clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // One register access, strobe dropped after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    got = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask : acc

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(n, e, got);
  endtask : rchk

  function automatic logic [7:0] exp_irq(input logic [7:0] c, input logic [7:0] m);
    return {7'h00, c[7] & |(8'hC0 & m)};
  endfunction : exp_irq

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    #(8 * 60000);
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    rchk("ctrl", 8'h28, 8'h04);
    rchk("mask", 8'h2B, 8'hD0);
    rchk("status", 8'h29, 8'h00);
    rchk("unmapped", 8'h30, 8'h00);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      mask = r[8] ? 8'hD0 : 8'h00;
      opt = {4'h0, r[0], i[2], 2'h0};
      ctl = {r[1], 1'b1, r[2], 1'b1, r[3], r[4], i[1:0]};
      tx = r[23:16];
      dat = r[31:24];
      acc(1'b1, 8'h2B, mask);
      acc(1'b1, 8'h38, opt);
      acc(1'b1, 8'h28, ctl);
      // A changed idle level must not look like an edge to the slave
      repeat (140) @(posedge clk_sys_i);
      sel_n <= 1'b0;
      acc(1'b1, 8'h2A, dat);
      acc(1'b1, 8'h2A, ~dat);
      k = 0;
      got = 8'h00;
      while (got[7] !== 1'b1 && k < 1200) begin
        acc(1'b0, 8'h29, 8'h00);
        k++;
      end
      chk("status", 8'hC0, got);
      chk("irq", exp_irq(ctl, mask), {7'h00, irq_o});
      rchk("rx", 8'h2A, tx);
      chk("sent", dat, mrx);
      rchk("clear", 8'h29, 8'h00);
      chk("irq off", 8'h00, {7'h00, irq_o});
      sel_n <= 1'b1;
      repeat (140) @(posedge clk_sys_i);
    end
    // Slave role against a bench-driven external master, mode 0
    sck_m <= 1'b0;
    acc(1'b1, 8'h38, 8'h00);
    acc(1'b1, 8'h28, 8'h40);
    r = $random(seed);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    acc(1'b1, 8'h2A, r[7:0]);
    for (int b = 7; b >= 0; b--) begin
      mosi_m <= r[8 + b];
      repeat (8) @(posedge clk_sys_i);
      sck_m <= 1'b1;
      srx = {srx[6:0], miso_d};
      repeat (8) @(posedge clk_sys_i);
      sck_m <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
    rchk("slv status", 8'h29, 8'h80);
    rchk("slv rx", 8'h2A, r[15:8]);
    chk("slv tx", r[7:0], srx);
    rchk("slv clear", 8'h29, 8'h00);
    ss_n_i <= 1'b1;
    sck_m <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    acc(1'b1, 8'h28, 8'h50);
    ss_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rchk("fault", 8'h29, 8'h10);
    rchk("ctrl", 8'h28, 8'h00);
    ss_n_i <= 1'b1;
    acc(1'b1, 8'h28, 8'h00);
    rchk("fault clr", 8'h29, 8'h00);
    acc(1'b1, 8'h2A, 8'h5A);
    repeat (40) @(posedge clk_sys_i);
    rchk("off", 8'h29, 8'h00);
    close_out();
  end
endmodule : ssp_port_tb_top
